//--- hdl/esp_pkg.sv
// Purpose: constants and types for the soft write protect block
// Assumes: 13-bit array byte address, 8-bit serial bytes
// Notes: encodings of the serial command set live here, except the device byte fields and read/write bit coded in esp_swp_core
`default_nettype none
package esp_pkg;
  localparam int ADDR_W = 13;
  localparam int PAGE_W = 5;
  localparam logic [3:0] TYPE_ARRAY = 4'hA;
  localparam logic [3:0] TYPE_ID = 4'hB;
  localparam logic [1:0] SEL_LOCK = 2'h1;
  localparam logic [1:0] SEL_DSC = 2'h3;
  localparam int SWP_SEL_BIT = 7;
  localparam int SEL_HI = 3;
  localparam int SEL_LO = 2;
  localparam int LOCK_DATA_BIT = 1;
  localparam int PROT_EN_BIT = 3;
  localparam int SIZE_HI = 2;
  localparam int SIZE_LO = 1;
  localparam int LOCK_BIT = 0;
  localparam logic [1:0] SIZE_QUARTER = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_3QUARTER = 2'h2;
  localparam logic [ADDR_W-1:0] BASE_QUARTER = 13'h1800;
  localparam logic [ADDR_W-1:0] BASE_HALF = 13'h1000;
  localparam logic [ADDR_W-1:0] BASE_3QUARTER = 13'h0800;
  localparam logic [ADDR_W-1:0] BASE_WHOLE = 13'h0000;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] FIRST_TX_BIT = 4'h1;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic [2:0] CNT_DEV = 3'h0;
  localparam logic [2:0] CNT_A0 = 3'h1;
  localparam logic [2:0] CNT_A1 = 3'h2;
  localparam logic [2:0] CNT_D1 = 3'h3;
  localparam logic [2:0] CNT_ONE = 3'h4;
  localparam logic [2:0] CNT_MORE = 3'h5;
  localparam logic [3:0] SWP_RST = 4'h0;
  localparam logic [2:0] DSC_RST = 3'h0;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_MACK = 5'h10
  } esp_state_e;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } esp_mem_wr_s;

  function automatic logic esp_prot_hit(input logic [3:0] cfg, input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] base;
    base = BASE_WHOLE;
    unique case (cfg[SIZE_HI:SIZE_LO])
      SIZE_QUARTER: base = BASE_QUARTER;
      SIZE_HALF: base = BASE_HALF;
      SIZE_3QUARTER: base = BASE_3QUARTER;
      default: base = BASE_WHOLE;
    endcase
    return cfg[PROT_EN_BIT] && (a >= base);
  endfunction : esp_prot_hit
endpackage : esp_pkg
`default_nettype wire

//--- hdl/esp_swp_core.sv
// Purpose: serial slave front end with soft write protect and select code registers
// Assumes: scl and sda are asynchronous pins, clk 25 MHz
// Notes: array storage and the timed write cycle sit outside; writes are offered on mem_wr
`default_nettype none
// Functional notes
// RULE1 - protect register is written by one-byte write with word address msb set
// RULE2 - data bits 7 to 4 of a protect register write are ignored
// RULE3 - more than one data byte abandons a register write, contents unchanged
// RULE4 - protect bit 3 enables protection of the selected block
// RULE5 - size field bits 2..1 pick quarter, half, three quarters or whole
// RULE6 - protected ranges start at 1800, 1000, 0800 or 0000 up to 1FFF
// RULE7 - writes into the protected block never change the array
// RULE8 - lock bit 0 freezes protect bits 3..0
// RULE9 - unused upper bits of both registers read zero
// RULE10 - select code written with type 1011 and word address A11 A10 equal 11
// RULE11 - after id page lock the select code stays frozen
// RULE12 - device address matches type 1010 or 1011 plus stored select code
// RULE13 - a read starts like a write with read/write bit set
// RULE14 - bit 0 picks direction; match acked low, mismatch goes to standby
// RULE15 - id lock uses type 1011, A11 A10 equal 01, data bit 1 set
// RULE16 - each received byte is acked low; stop starts the write
// RULE17 - protect register reads zeros above bit 3, repeating on multi-byte reads
// RULE18 - locked protect writes still handshake but change nothing
// RULE19 - both registers clear at reset and otherwise keep their values
module esp_swp_core (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output esp_pkg::esp_mem_wr_s mem_wr,
  output logic mem_wr_refused,
  output logic [7:0] protect_cfg,
  output logic [2:0] select_code_bits,
  output logic id_locked
);
  import esp_pkg::*;

  logic [2:0] scl_sync_r, scl_sync_nxt, sda_sync_r, sda_sync_nxt;
  logic scl_f_r, scl_f_nxt, sda_f_r, sda_f_nxt, scl_p_r, sda_p_r;
  logic rise, fall, start, stop;

  // three-stage sync; a level counts only once stages two and three agree
  always_comb begin
    scl_sync_nxt = {scl_sync_r[1:0], scl_i};
    sda_sync_nxt = {sda_sync_r[1:0], sda_i};
    scl_f_nxt = (scl_sync_r[1] == scl_sync_r[2]) ? scl_sync_r[2] : scl_f_r;
    sda_f_nxt = (sda_sync_r[1] == sda_sync_r[2]) ? sda_sync_r[2] : sda_f_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_sync_r <= scl_sync_nxt;
      sda_sync_r <= sda_sync_nxt;
      scl_f_r <= scl_f_nxt;
      sda_f_r <= sda_f_nxt;
      scl_p_r <= scl_f_r;
      sda_p_r <= sda_f_r;
    end
  end

  assign rise = scl_f_r & ~scl_p_r;
  assign fall = ~scl_f_r & scl_p_r;
  assign start = scl_f_r & scl_p_r & ~sda_f_r & sda_p_r;
  assign stop = scl_f_r & scl_p_r & sda_f_r & ~sda_p_r;

  esp_state_e st_r, st_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [7:0] rx_r, rx_nxt, tx_r, tx_nxt, a0_r, a0_nxt, a1_r, a1_nxt, d_r, d_nxt;
  logic rd_r, rd_nxt, idsel_r, idsel_nxt, oe_r, oe_nxt;
  logic [3:0] swp_r, swp_nxt;
  logic [2:0] dsc_r, dsc_nxt;
  logic idlk_r, idlk_nxt;
  esp_mem_wr_s mw_r, mw_nxt;
  logic ref_r, ref_nxt;
  logic [7:0] rdata;
  logic [ADDR_W-1:0] arr_addr;
  logic dev_match, is_swp, is_dsc, is_lock;

  assign dev_match = ((rx_r[7:4] == TYPE_ARRAY) || (rx_r[7:4] == TYPE_ID))
                     && (rx_r[3:1] == dsc_r);                               // [RULE12]
  assign is_swp = !idsel_r && a0_r[SWP_SEL_BIT];                            // [RULE1]
  assign is_dsc = idsel_r && (a0_r[SEL_HI:SEL_LO] == SEL_DSC);             // [RULE10]
  assign is_lock = idsel_r && (a0_r[SEL_HI:SEL_LO] == SEL_LOCK);           // [RULE15]
  assign arr_addr = {a0_r[PAGE_W-1:0], a1_r};
  // the protect register loops on itself, so multi-byte reads repeat it
  assign rdata = is_swp ? {4'h0, swp_r}
                 : (is_dsc ? {5'h00, dsc_r} : IDLE_BYTE);                   // [RULE17] [RULE9]

  always_comb begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    cnt_nxt = cnt_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    a0_nxt = a0_r;
    a1_nxt = a1_r;
    d_nxt = d_r;
    rd_nxt = rd_r;
    idsel_nxt = idsel_r;
    oe_nxt = oe_r;
    swp_nxt = swp_r;
    dsc_nxt = dsc_r;
    idlk_nxt = idlk_r;
    mw_nxt = '0;
    mw_nxt.addr = mw_r.addr;
    mw_nxt.data = mw_r.data;
    ref_nxt = 1'b0;
    if (start) begin
      st_nxt = ST_RX;
      bit_nxt = 4'h0;
      cnt_nxt = CNT_DEV;
      oe_nxt = 1'b0;
    end else if (stop) begin
      // register commands commit only at stop and only with exactly one data byte
      if (!rd_r && cnt_r == CNT_ONE) begin                                  // [RULE3] [RULE16]
        if (is_swp && !swp_r[LOCK_BIT])                                     // [RULE8] [RULE18]
          swp_nxt = d_r[3:0];                                               // [RULE2]
        if (is_dsc && !idlk_r)                                              // [RULE11]
          dsc_nxt = d_r[2:0];                                               // [RULE10]
        if (is_lock && d_r[LOCK_DATA_BIT])                                  // [RULE15]
          idlk_nxt = 1'b1;
      end
      st_nxt = ST_IDLE;
      oe_nxt = 1'b0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
        end
        ST_RX: begin
          if (rise) begin
            rx_nxt = {rx_r[6:0], sda_f_r};
            bit_nxt = bit_r + 4'h1;
          end else if (fall && bit_r == BYTE_BITS) begin
            bit_nxt = 4'h0;
            st_nxt = ST_ACK;
            oe_nxt = 1'b1;                                                  // [RULE16]
            if (cnt_r != CNT_MORE)
              cnt_nxt = cnt_r + 3'h1;
            unique case (cnt_r)
              CNT_DEV: begin
                if (dev_match) begin
                  rd_nxt = rx_r[0];                                         // [RULE14] [RULE13]
                  idsel_nxt = (rx_r[7:4] == TYPE_ID);
                end else begin
                  st_nxt = ST_IDLE;                                         // [RULE14]
                  oe_nxt = 1'b0;
                end
              end
              CNT_A0: a0_nxt = rx_r;
              CNT_A1: a1_nxt = rx_r;
              default: begin
                if (cnt_r == CNT_D1)
                  d_nxt = rx_r;
                if (!idsel_r && !a0_r[SWP_SEL_BIT]) begin
                  // protected writes are still acked, only the array is spared
                  if (esp_prot_hit(swp_r, arr_addr)) begin                  // [RULE4] [RULE5] [RULE6]
                    ref_nxt = 1'b1;                                         // [RULE7]
                  end else begin
                    mw_nxt.valid = 1'b1;
                    mw_nxt.addr = arr_addr;
                    mw_nxt.data = rx_r;
                  end
                  a1_nxt[PAGE_W-1:0] = a1_r[PAGE_W-1:0] + 5'h01;
                end
              end
            endcase
          end
        end
        ST_ACK, ST_MACK: begin
          if (st_r == ST_MACK && rise && sda_f_r) begin
            st_nxt = ST_IDLE;
          end else if (fall) begin
            if (rd_r) begin
              oe_nxt = ~rdata[7];
              tx_nxt = {rdata[6:0], 1'b0};
              bit_nxt = FIRST_TX_BIT;
              st_nxt = ST_TX;
            end else begin
              oe_nxt = 1'b0;
              st_nxt = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (fall) begin
            if (bit_r == BYTE_BITS) begin
              oe_nxt = 1'b0;
              st_nxt = ST_MACK;
            end else begin
              oe_nxt = ~tx_r[7];
              tx_nxt = {tx_r[6:0], 1'b0};
              bit_nxt = bit_r + 4'h1;
            end
          end
        end
        default: begin
          st_nxt = ST_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // nonvolatile content is modelled as flops cleared only by rst_b
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= ST_IDLE;
      bit_r <= 4'h0;
      cnt_r <= CNT_DEV;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      a0_r <= 8'h00;
      a1_r <= 8'h00;
      d_r <= 8'h00;
      rd_r <= 1'b0;
      idsel_r <= 1'b0;
      oe_r <= 1'b0;
      swp_r <= SWP_RST;                                                     // [RULE19]
      dsc_r <= DSC_RST;                                                     // [RULE19]
      idlk_r <= 1'b0;
      mw_r <= '0;
      ref_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      cnt_r <= cnt_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      a0_r <= a0_nxt;
      a1_r <= a1_nxt;
      d_r <= d_nxt;
      rd_r <= rd_nxt;
      idsel_r <= idsel_nxt;
      oe_r <= oe_nxt;
      swp_r <= swp_nxt;
      dsc_r <= dsc_nxt;
      idlk_r <= idlk_nxt;
      mw_r <= mw_nxt;
      ref_r <= ref_nxt;
    end
  end

  // open drain: the pin is only ever pulled low
  assign sda_o = 1'b0;
  assign sda_oe = oe_r;
  assign mem_wr = mw_r;
  assign mem_wr_refused = ref_r;
  assign protect_cfg = {4'h0, swp_r};                                       // [RULE9]
  assign select_code_bits = dsc_r;
  assign id_locked = idlk_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_swp_lock_freeze: assert property (swp_r[LOCK_BIT] |=> swp_r == $past(swp_r)) // [RULE8]
    else $error("protect bits changed while locked");
  a_dsc_id_freeze: assert property (idlk_r |=> dsc_r == $past(dsc_r)) // [RULE11]
    else $error("select code changed after id lock");
  a_upper_bits_zero: assert property (protect_cfg[7:4] == 4'h0) // [RULE9]
    else $error("protect register upper bits not zero");
  a_no_prot_write: assert property (mw_r.valid |-> !esp_prot_hit(swp_r, mw_r.addr)) // [RULE7]
    else $error("array write issued into protected block");
  a_addr_mismatch: assert property (st_r == ST_RX && fall && bit_r == BYTE_BITS
      && cnt_r == CNT_DEV && !dev_match |=> st_r == ST_IDLE && !sda_oe) // [RULE14]
    else $error("mismatched device address not sent to standby");
  a_multi_byte: assert property (stop && cnt_r == CNT_MORE |=> swp_r == $past(swp_r)
      && dsc_r == $past(dsc_r)) // [RULE3]
    else $error("multi-byte register write changed a register");
  a_swp_write: assert property (stop && !rd_r && cnt_r == CNT_ONE && is_swp
      && !swp_r[LOCK_BIT] |=> swp_r == $past(d_r[3:0])) // [RULE1]
    else $error("protect register write not applied");
  a_dsc_write: assert property (stop && !rd_r && cnt_r == CNT_ONE && is_dsc
      && !idlk_r |=> dsc_r == $past(d_r[2:0])) // [RULE10]
    else $error("select code write not applied");
  a_ack_release: assert property (st_r == ST_ACK && fall && !rd_r |=> !sda_oe ##1 st_r == ST_RX
      || start || stop) // [RULE16]
    else $error("ack not released after ninth clock");
endmodule : esp_swp_core
`default_nettype wire

//--- verification/esp_i2c_master.sv
// Purpose: two-wire bus master model that drives the serial pins of the protect block
// Assumes: pull-up on the data line; a quarter bit of 7 clk keeps setup and hold
// Notes: the serial clock stands high between frames; sda_drv high means released
`default_nettype none
module esp_i2c_master (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hp(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : hp
  // also serves as repeated start, entered with the clock low
  task automatic start();
    sda_drv = 1'b1;
    hp(7);
    scl = 1'b1;
    hp(14);
    sda_drv = 1'b0;
    hp(14);
    scl = 1'b0;
    hp(7);
  endtask : start
  // stop after a write commits the register update
  task automatic stop();
    sda_drv = 1'b0;
    hp(7);
    scl = 1'b1;
    hp(14);
    sda_drv = 1'b1;
    hp(14);
  endtask : stop
  // eight bits msb first, then the ack slot, released or driven by last
  task automatic xbyte(input logic [7:0] b, input logic last, output logic [7:0] got,
                       output logic ack);
    logic s;
    for (int i = 0; i < 9; i++) begin
      sda_drv = (i < 8) ? b[7-i] : last;
      hp(7);
      scl = 1'b1;
      hp(7);
      s = sda_line;
      hp(7);
      scl = 1'b0;
      hp(7);
      if (i < 8) got = {got[6:0], s};
      else ack = s;
    end
  endtask : xbyte
endmodule : esp_i2c_master
`default_nettype wire

//--- verification/tb.sv
// Purpose: self-checking bench for the soft write protect block
// Assumes: 25 MHz clock, master model at 28 clk per bit
// Notes: array write outcomes are queued by the driver and matched by a watcher
`default_nettype none
module tb;
  import esp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_b = 1'b0, scl, sda_drv, sda_o, sda_oe, mem_wr_refused, id_locked;
  logic [7:0] protect_cfg, v, g;
  logic [2:0] select_code_bits, sc = 3'h0;
  logic [12:0] base;
  logic [21:0] q[$];
  esp_mem_wr_s mem_wr;
  int error_cnt = 0, compares = 0;
  // open drain: line low when either side pulls
  wire logic sda_line = sda_drv & ~(sda_oe & ~sda_o);
  always #20 clk = ~clk;
  esp_i2c_master m (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
  esp_swp_core dut (.clk(clk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .mem_wr(mem_wr), .mem_wr_refused(mem_wr_refused),
    .protect_cfg(protect_cfg), .select_code_bits(select_code_bits), .id_locked(id_locked));
  task automatic chk(input string what, input logic [21:0] exp, input logic [21:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic give_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    if (rst_b && (mem_wr.valid || mem_wr_refused)) begin
      if (q.size() == 0) chk("mem event", 22'h0, 22'h3FFFFF);
      else chk("mem event", q.pop_front(), mem_wr_refused ? 22'h200000
        : {1'b0, mem_wr.addr, mem_wr.data});
    end
  end
  task automatic tx(input logic [7:0] b, input logic exp_ack);
    logic a;
    m.xbyte(b, 1'b1, g, a);
    chk("ack", 22'(exp_ack), 22'(a));
  endtask : tx
  task automatic wr(input logic [3:0] t, input logic [7:0] a0, a1, d, input int n,
                    input logic nak = 1'b0);
    m.start();
    tx({t, sc, 1'b0}, nak);
    if (!nak) begin
      tx(a0, 1'b0);
      tx(a1, 1'b0);
      repeat (n) tx(d, 1'b0);
    end
    m.stop();
    m.hp(4);
  endtask : wr
  task automatic rd(input logic [3:0] t, input logic [7:0] a0, exp, input int n);
    logic a;
    m.start();
    tx({t, sc, 1'b0}, 1'b0);
    tx(a0, 1'b0);
    tx(8'h00, 1'b0);
    m.start();
    tx({t, sc, 1'b1}, 1'b0);
    for (int i = 0; i < n; i++) begin
      m.xbyte(8'hFF, i == n - 1, g, a);
      chk("read byte", 22'(exp), 22'(g));
    end
    m.stop();
  endtask : rd
  task automatic arr(input logic [12:0] a, input logic refused);
    logic [7:0] d;
    d = 8'($urandom);
    q.push_back(refused ? 22'h200000 : {1'b0, a, d});
    wr(TYPE_ARRAY, {3'h0, a[12:8]}, a[7:0], d, 1);
  endtask : arr
  task automatic cfg_wr(input logic [7:0] d, input logic [3:0] exp);
    wr(TYPE_ARRAY, 8'h80 | 8'($urandom), 8'($urandom), d, 1);
    chk("protect cfg", 22'({4'h0, exp}), 22'(protect_cfg));
  endtask : cfg_wr
  initial begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    void'($urandom(97));
    repeat (4) @(posedge clk);
    #2 rst_b = 1'b1;
    m.hp(4);
    chk("reset", 22'h0, {8'h0, sda_o, sda_oe, protect_cfg, select_code_bits, id_locked});
    arr(13'h1FFF, 1'b0);
    for (int s = 0; s < 4; s++) begin
      v = {4'($urandom), 1'b1, 2'(s), 1'b0};
      cfg_wr(v, v[3:0]);
      rd(TYPE_ARRAY, 8'h80, {4'h0, v[3:0]}, 2);
      base = 13'h1800 - 13'(13'h0800 * s);
      if (s != 3) arr(base - 13'h1, 1'b0);
      arr(base, 1'b1);
    end
    wr(TYPE_ARRAY, 8'h80, 8'h00, 8'h00, 2);
    chk("two byte write", 22'hE, 22'(protect_cfg));
    cfg_wr(8'h00, 4'h0);
    arr(13'h0000, 1'b0);
    $display("protect tests done");
    wr(4'h2, 8'h00, 8'h00, 8'h00, 1, 1'b1);
    wr(4'hE, 8'h00, 8'h00, 8'h00, 1, 1'b1);
    sc = 3'h1;
    wr(TYPE_ARRAY, 8'h00, 8'h00, 8'h00, 1, 1'b1);
    sc = 3'h0;
    wr(TYPE_ID, 8'h0C, 8'h00, 8'hF5, 1);
    chk("select code", 22'h5, 22'(select_code_bits));
    wr(TYPE_ARRAY, 8'h80, 8'h00, 8'h00, 0, 1'b1);
    sc = 3'h5;
    rd(TYPE_ID, 8'h0C, 8'h05, 1);
    wr(TYPE_ID, 8'h04, 8'h00, 8'h02, 1);
    chk("id lock", 22'h1, 22'(id_locked));
    wr(TYPE_ID, 8'h0C, 8'h00, 8'h02, 1);
    chk("select frozen", 22'h5, 22'(select_code_bits));
    $display("select code tests done");
    cfg_wr(8'h0B, 4'hB);
    cfg_wr(8'h00, 4'hB);
    arr(13'h0FFF, 1'b0);
    arr(13'h1000, 1'b1);
    m.hp(40);
    chk("pending events", 22'h0, 22'(q.size()));
    $display("lock tests done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
